// *** hdl/slk_rx.sv ***
// Serial link receiver: frame recovery, lock detection, buffering and parallel outputs
`timescale 1ns/10ps

module slk_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  // Count is one bit wider so that full and empty stay apart
  logic [AW:0]      cnt_r;
  logic             do_wr;
  logic             do_rd;

  // Pointers wrap at DEPTH, which need not be a power of two
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (do_rd) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      case ({do_wr, do_rd})
        2'b10:   cnt_r <= (AW+1)'(cnt_r + 1'b1);
        2'b01:   cnt_r <= (AW+1)'(cnt_r - 1'b1);
        default: cnt_r <= cnt_r;
      endcase
    end
  end
endmodule

module slk_rx (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial link from the transmitter
  input  wire logic        link_bit_clock,
  input  wire logic        serial_input_pair,
  // Power and control pins
  input  wire logic        supply_ok,
  input  wire logic        receiver_power_down_n,
  // Consumer flow control
  input  wire logic        sink_ready,
  // Parallel outputs
  output logic [23:0]      parallel_data_out,
  output logic             parallel_out_en,
  output logic             recovered_clock_out,
  output logic             lock_flag
);
  logic                          lclk_s1_r;
  logic                          lclk_s2_r;
  logic                          lclk_s3_r;
  logic                          sdat_s1_r;
  logic                          sdat_s2_r;
  logic                          sok_s1_r;
  logic                          sok_s2_r;
  logic                          pdn_s1_r;
  logic                          pdn_s2_r;
  logic                          run;
  logic                          bit_edge;
  logic [slk_pkg::WIN_W-1:0]     win_r;
  logic [slk_pkg::WIN_W-1:0]     win_nxt;
  logic                          win_ok;
  slk_pkg::slk_state_type        st_r;
  logic [4:0]                    bit_cnt_r;
  logic [2:0]                    good_cnt_r;
  logic                          frame_end;
  logic                          frame_start;
  logic                          push;
  logic                          pop;
  logic                          overflow;
  logic [slk_pkg::PAYLOAD_W-1:0] word;
  logic                          fifo_in_ready;
  logic                          fifo_out_valid;
  logic [slk_pkg::PAYLOAD_W-1:0] fifo_out_data;
  logic [7:0]                    gap_cnt_r;
  logic                          gap_hit;

  // Marker pair frames the rising embedded clock edge; parity covers payload and balance bit
  function automatic logic frame_ok(input logic [slk_pkg::WIN_W-1:0] w);
    frame_ok = (w[slk_pkg::POS_PREV_LOW] == 1'b0) && (w[slk_pkg::POS_HIGH] == 1'b1) &&
               (w[slk_pkg::POS_LOW] == 1'b0) &&
               ((^w[slk_pkg::POS_PAY_MSB:slk_pkg::POS_INT]) == 1'b0);
  endfunction

  // One bit position of the frame, seen at the edge that takes that bit
  function automatic logic at_bit(input logic seen, input logic [4:0] cnt, input logic [4:0] mark);
    at_bit = seen && (cnt == mark);
  endfunction

  // Link clock and serial data each pass two flops; s3 only follows s2 for edge finding
  always_ff @(posedge clk) begin
    if (rst) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_s3_r <= 1'b0;
      sdat_s1_r <= 1'b0;
      sdat_s2_r <= 1'b0;
    end else begin
      lclk_s1_r <= link_bit_clock;
      lclk_s2_r <= lclk_s1_r;
      lclk_s3_r <= lclk_s2_r;
      sdat_s1_r <= serial_input_pair;
      sdat_s2_r <= sdat_s1_r;
    end
  end

  // Supply and power-down pins, synchronised the same way
  always_ff @(posedge clk) begin
    if (rst) begin
      sok_s1_r  <= 1'b0;
      sok_s2_r  <= 1'b0;
      pdn_s1_r  <= 1'b0;
      pdn_s2_r  <= 1'b0;
    end else begin
      sok_s1_r  <= supply_ok;
      sok_s2_r  <= sok_s1_r;
      pdn_s1_r  <= receiver_power_down_n;
      pdn_s2_r  <= pdn_s1_r;
    end
  end

  // Losing either supply or power-down enable is a full restart of acquisition
  assign run      = sok_s2_r & pdn_s2_r;
  assign bit_edge = lclk_s2_r & ~lclk_s3_r;
  assign win_nxt  = {win_r[slk_pkg::WIN_W-2:0], sdat_s2_r};
  assign win_ok   = frame_ok(win_nxt);

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      win_r <= '0;
    end else if (bit_edge) begin
      win_r <= win_nxt;
    end
  end

  // A silent line (transmitter off or unplugged) never fails a frame check,
  // so a bit edge overdue by this many cycles counts as a missing clock edge
  always_ff @(posedge clk) begin
    if (rst || !run || bit_edge) begin
      gap_cnt_r <= 8'h00;
    end else if (!gap_hit) begin
      gap_cnt_r <= 8'(gap_cnt_r + 1'b1);
    end
  end

  assign gap_hit     = (gap_cnt_r == slk_pkg::BIT_GAP_MAX);
  assign frame_end   = at_bit(bit_edge, bit_cnt_r, slk_pkg::LAST_BIT) &&
                       ((st_r == slk_pkg::ST_ALIGN) || (st_r == slk_pkg::ST_LOCK));
  assign frame_start = at_bit(bit_edge, bit_cnt_r, slk_pkg::FIRST_BIT) && (st_r == slk_pkg::ST_LOCK);
  assign push        = frame_end && win_ok && (st_r == slk_pkg::ST_LOCK);
  // A full buffer cannot take the word; losing lock beats handing out a gap in the stream
  assign overflow    = push && !fifo_in_ready;
  // sink_ready is already on this clock, so it needs no synchroniser
  assign pop         = frame_start && fifo_out_valid && sink_ready;
  // Undo the transmitter's inversion choice
  assign word        = win_nxt[slk_pkg::POS_BAL] ? ~win_nxt[slk_pkg::POS_PAY_MSB:slk_pkg::POS_PAY_LSB]
                                                 : win_nxt[slk_pkg::POS_PAY_MSB:slk_pkg::POS_PAY_LSB];

  // Acquisition needs no reference and no special pattern: any frame with valid
  // markers and parity seeds alignment, which relies on the far end having locked
  // and sending ordinary data. Lock takes a few frames, far below the 50 ms bound.
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      st_r       <= slk_pkg::ST_OFF;
      bit_cnt_r  <= slk_pkg::FIRST_BIT;
      good_cnt_r <= 3'h0;
    end else begin
      case (st_r)
        slk_pkg::ST_OFF: begin
          st_r <= slk_pkg::ST_HUNT;
        end
        slk_pkg::ST_HUNT: begin
          if (bit_edge && win_ok) begin
            st_r       <= slk_pkg::ST_ALIGN;
            bit_cnt_r  <= slk_pkg::FIRST_BIT;
            good_cnt_r <= 3'h0;
          end
        end
        slk_pkg::ST_ALIGN, slk_pkg::ST_LOCK: begin
          if (overflow) begin
            st_r <= slk_pkg::ST_HUNT;
          end else if (gap_hit) begin
            st_r <= slk_pkg::ST_HUNT;
          end else if (bit_edge) begin
            if (bit_cnt_r == slk_pkg::LAST_BIT) begin
              bit_cnt_r <= slk_pkg::FIRST_BIT;
              if (!win_ok) begin
                st_r <= slk_pkg::ST_HUNT;
              end else if (st_r == slk_pkg::ST_ALIGN) begin
                if (good_cnt_r == slk_pkg::LOCK_FRAMES_M1) begin
                  st_r <= slk_pkg::ST_LOCK;
                end else begin
                  good_cnt_r <= 3'(good_cnt_r + 1'b1);
                end
              end
            end else begin
              bit_cnt_r <= 5'(bit_cnt_r + 1'b1);
            end
          end
        end
        default: begin
          st_r <= slk_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Absorbs consumer stalls; a word lost to a full buffer costs the lock
  slk_fifo #(
    .WIDTH (slk_pkg::PAYLOAD_W),
    .DEPTH (slk_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (st_r != slk_pkg::ST_LOCK),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (word),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // New words and recovered clock rises come only at frame starts, so while sink_ready stays high the recovered clock period is one frame
  always_ff @(posedge clk) begin
    if (rst || (st_r != slk_pkg::ST_LOCK) || overflow) begin
      parallel_data_out   <= '0;
      parallel_out_en     <= 1'b0;
      recovered_clock_out <= 1'b0;
      lock_flag           <= 1'b0;
    end else if (pop) begin
      parallel_data_out   <= fifo_out_data;
      parallel_out_en     <= 1'b1;
      recovered_clock_out <= 1'b1;
      lock_flag           <= 1'b1;
    end else if (at_bit(bit_edge, bit_cnt_r, slk_pkg::RCLK_FALL_BIT)) begin
      // Falling halfway through the frame keeps the duty cycle near one half
      recovered_clock_out <= 1'b0;
    end
  end

endmodule

// *** hdl/slk_pkg.sv ***
// Constants and types shared by the serial link receiver
package slk_pkg;

  // Frame layout: oldest bit of the window is the previous frame's low marker
  localparam int unsigned PAYLOAD_W    = 24;
  localparam int unsigned FRAME_BITS   = 28;
  localparam int unsigned WIN_W        = 29;
  localparam int unsigned POS_PREV_LOW = 28;
  localparam int unsigned POS_HIGH     = 27;
  localparam int unsigned POS_PAY_MSB  = 26;
  localparam int unsigned POS_PAY_LSB  = 3;
  localparam int unsigned POS_BAL      = 2;
  localparam int unsigned POS_INT      = 1;
  localparam int unsigned POS_LOW      = 0;

  // Bit counter marks within one frame
  localparam logic [4:0] LAST_BIT      = 5'h1B;
  localparam logic [4:0] FIRST_BIT     = 5'h00;
  localparam logic [4:0] RCLK_FALL_BIT = 5'h0E;

  // Consecutive good frames needed before lock, minus one
  localparam logic [2:0] LOCK_FRAMES_M1 = 3'h3;

  // Clock cycles without a link bit edge before an aligned link is given up
  localparam logic [7:0] BIT_GAP_MAX = 8'hFF;

  // Buffer between decoder and parallel outputs
  localparam int unsigned FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_HUNT  = 2'b01,
    ST_ALIGN = 2'b10,
    ST_LOCK  = 2'b11
  } slk_state_type;

endpackage

// *** verification/slk_rx_asserts.sv ***
// Port assertions for the serial link receiver
`timescale 1ns/10ps
module slk_rx_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Link and control
  input wire logic        link_bit_clock,
  input wire logic        serial_input_pair,
  input wire logic        supply_ok,
  input wire logic        receiver_power_down_n,
  input wire logic        sink_ready,
  // Parallel side
  input wire logic [23:0] parallel_data_out,
  input wire logic        parallel_out_en,
  input wire logic        recovered_clock_out,
  input wire logic        lock_flag
);
  logic [15:0] up_r;
  logic [15:0] hi_r;
  logic [9:0]  quiet_r;
  logic        lbc_q;
  // Reset, loss of supply or power-down restarts the up time
  always_ff @(posedge clk) begin
    if (rst || !supply_ok || !receiver_power_down_n) up_r <= 16'h0000;
    else if (up_r != 16'hFFFF) up_r <= up_r + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (!recovered_clock_out) hi_r <= 16'h0000;
    else hi_r <= hi_r + 16'h0001;
  end
  // A link clock that stops changing is a run of missing embedded clock edges
  always_ff @(posedge clk) begin
    lbc_q <= link_bit_clock;
    if (rst || (link_bit_clock != lbc_q)) quiet_r <= 10'h000;
    else if (quiet_r != 10'h3FF) quiet_r <= quiet_r + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_en_lock; parallel_out_en == lock_flag; endproperty
  a_en_lock: assert property (p_en_lock) else $error("enable and lock differ");
  property p_off_zero; !parallel_out_en |-> parallel_data_out == 24'h000000 && !recovered_clock_out; endproperty
  a_off_zero: assert property (p_off_zero) else $error("outputs active while disabled");
  property p_rise_together; $rose(lock_flag) |-> recovered_clock_out && parallel_out_en; endproperty
  a_rise_together: assert property (p_rise_together) else $error("lock rose without clock");
  property p_pd_low; !receiver_power_down_n [*5] |-> !lock_flag; endproperty
  a_pd_low: assert property (p_pd_low) else $error("lock high in power-down");
  property p_supply; !supply_ok [*5] |-> !lock_flag && !parallel_out_en; endproperty
  a_supply: assert property (p_supply) else $error("active without supply");
  property p_acquire; $rose(lock_flag) |-> up_r > 16'h0FA0; endproperty
  a_acquire: assert property (p_acquire) else $error("lock without enough frames");
  property p_hold; lock_flag && $past(lock_flag) && !$rose(recovered_clock_out) |-> $stable(parallel_data_out); endproperty
  a_hold: assert property (p_hold) else $error("data changed between words");
  property p_high_time; $fell(recovered_clock_out) && lock_flag |-> hi_r >= 16'h022C && hi_r <= 16'h0234; endproperty
  a_high_time: assert property (p_high_time) else $error("clock high time wrong");
  property p_rise_cause; $rose(recovered_clock_out) |-> link_bit_clock && $past(sink_ready); endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("word out of step");
  property p_gap_drop; quiet_r > 10'h110 |-> !lock_flag; endproperty
  a_gap_drop: assert property (p_gap_drop) else $error("lock held on a silent link");
endmodule

bind slk_rx slk_rx_asserts u_slk_rx_asserts (.clk(clk), .rst(rst), .link_bit_clock(link_bit_clock),
  .serial_input_pair(serial_input_pair), .supply_ok(supply_ok), .receiver_power_down_n(receiver_power_down_n),
  .sink_ready(sink_ready), .parallel_data_out(parallel_data_out), .parallel_out_en(parallel_out_en),
  .recovered_clock_out(recovered_clock_out), .lock_flag(lock_flag));

// *** verification/slk_ser_model.sv ***
// Behavioural transmitter sending framed serial words
`timescale 1ns/10ps
module slk_ser_model (
  // Frame source
  input wire logic        run,
  input wire logic [23:0] word,
  input wire logic        inv,
  input wire logic        corrupt,
  // Serial link
  output logic            link_bit_clock,
  output logic            serial_input_pair,
  output logic            loaded
);
  logic [27:0] frame;
  logic [23:0] sent;
  int          i;
  initial begin
    link_bit_clock = 1'b0;
    serial_input_pair = 1'b0;
    loaded = 1'b0;
    forever begin
      // Link clock stops at the next frame boundary once run is low
      wait (run === 1'b1);
      sent = inv ? ~word : word;
      frame = {!corrupt, sent, inv, ^{sent, inv}, 1'b0};
      loaded = !loaded;
      for (i = 27; i >= 0; i--) begin
        serial_input_pair = frame[i];
        #80 link_bit_clock = 1'b1;
        #80 link_bit_clock = 1'b0;
      end
      // A released line must not look like a held bit
      if (!run) serial_input_pair = !serial_input_pair;
    end
  end
endmodule

// *** verification/slk_rx_test.sv ***
// Self-checking bench for the serial link receiver
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module slk_rx_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        supply_ok = 1'b1;
  logic        receiver_power_down_n = 1'b1;
  logic        sink_ready = 1'b1;
  logic        run = 1'b0;
  logic [23:0] word = 24'h000000;
  logic        inv = 1'b0;
  logic        corrupt = 1'b0;
  logic        steady = 1'b0;
  logic        rco_q = 1'b0;
  logic        lock_q = 1'b0;
  logic        link_bit_clock;
  logic        serial_input_pair;
  logic        loaded;
  logic [23:0] parallel_data_out;
  logic        parallel_out_en;
  logic        recovered_clock_out;
  logic        lock_flag;
  logic [23:0] exp_w;
  logic [23:0] exp_q[$];
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          skips;
  realtime     t_last = 0.0;
  initial forever #2 clk = ~clk;
  slk_rx u_slk_rx (.clk(clk), .rst(rst), .link_bit_clock(link_bit_clock), .serial_input_pair(serial_input_pair),
    .supply_ok(supply_ok), .receiver_power_down_n(receiver_power_down_n), .sink_ready(sink_ready),
    .parallel_data_out(parallel_data_out), .parallel_out_en(parallel_out_en),
    .recovered_clock_out(recovered_clock_out), .lock_flag(lock_flag));
  slk_ser_model u_slk_ser_model (.run(run), .word(word), .inv(inv), .corrupt(corrupt),
    .link_bit_clock(link_bit_clock), .serial_input_pair(serial_input_pair), .loaded(loaded));
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_lock(input logic v, input int lim);
    for (int n = 0; n < lim && lock_flag !== v; n++) @(negedge clk);
    `CHK("lock_flag", v, lock_flag)
  endtask
  task automatic frames(input int n);
    repeat (n) @(loaded);
  endtask
  task automatic done(input string s);
    $display("test %s finished, errors %0d", s, errors);
  endtask
  // Each word is noted as the transmitter takes it; corrupted frames carry none
  always @(loaded) begin
    if (corrupt === 1'b0) exp_q.push_back(word);
    @(negedge clk);
    word <= 24'($urandom);
    inv <= 1'($urandom);
    corrupt <= 1'b0;
  end
  // Words sent before lock never appear, so the first word after lock is searched for
  always @(negedge clk) begin
    if (recovered_clock_out && !rco_q) begin
      skips = 0;
      while (!lock_q && exp_q.size() > 1 && exp_q[0] !== parallel_data_out && skips < 32) begin
        void'(exp_q.pop_front());
        skips++;
      end
      if (exp_q.size() > 0) begin
        exp_w = exp_q.pop_front();
        `CHK("parallel_data_out", exp_w, parallel_data_out)
      end
      if (steady && lock_q) `CHK("period", 1'b1, ($realtime - t_last) > 4470.0 && ($realtime - t_last) < 4490.0)
      t_last = $realtime;
    end
    rco_q = recovered_clock_out;
    lock_q = lock_flag;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(88860));
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (3) @(negedge clk);
    run = 1'b1;
    wait_lock(1'b1, 12000);
    steady = 1'b1;
    frames(8);
    steady = 1'b0;
    done("stream");
    @(loaded);
    repeat (2) @(negedge clk);
    corrupt = 1'b1;
    wait_lock(1'b0, 2500);
    wait_lock(1'b1, 20000);
    frames(2);
    done("resync");
    @(negedge clk) receiver_power_down_n = 1'b0;
    wait_lock(1'b0, 6);
    frames(1);
    `CHK("parallel_out_en", 1'b0, parallel_out_en)
    @(negedge clk) supply_ok = 1'b0;
    receiver_power_down_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("lock_flag", 1'b0, lock_flag)
    supply_ok = 1'b1;
    wait_lock(1'b1, 20000);
    done("power");
    @(negedge clk) sink_ready = 1'b0;
    frames(4);
    `CHK("lock_flag", 1'b1, lock_flag)
    @(negedge clk) sink_ready = 1'b1;
    frames(5);
    @(negedge clk) sink_ready = 1'b0;
    wait_lock(1'b0, 12000);
    @(negedge clk) sink_ready = 1'b1;
    wait_lock(1'b1, 20000);
    frames(2);
    done("buffer");
    run = 1'b0;
    wait_lock(1'b0, 2000);
    done("gap");
    summarize();
  end
endmodule
